// *** grc_activity.sv ***
// Receive activity and collision detector for the repeater ports
`timescale 1ns/1ps
module grc_activity
  import grc_pkg::*;
(
  input wire logic [grc_pkg::NUM_PORTS-1:0] rx_dv_i,
  input wire logic [grc_pkg::NUM_PORTS-1:0] rx_er_i,
  output logic [grc_pkg::NUM_PORTS-1:0] active_o,
  output logic any_o,
  output logic collision_o,
  output logic [grc_pkg::PORT_IDX_W-1:0] first_o
);

  logic [PORT_IDX_W:0] count;

  always_comb
  begin
    // Error without valid is a receive event too, so false carrier is seen
    active_o = rx_dv_i | rx_er_i;
    count = grc_count(active_o);
    any_o = (count != '0);
    collision_o = (count > (PORT_IDX_W + 1)'(1));
    first_o = grc_lowest(active_o);
  end

endmodule : grc_activity

// *** grc_core.sv ***
// Forwarding, error substitution and jam logic of the repeater core
`timescale 1ns/1ps
module grc_core
  import grc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [grc_pkg::NUM_PORTS-1:0] rx_dv_i,
  input wire logic [grc_pkg::NUM_PORTS-1:0] rx_er_i,
  input wire logic [grc_pkg::BUS_W-1:0] rxd_i,
  output logic [grc_pkg::NUM_PORTS-1:0] tx_en_o,
  output logic [grc_pkg::NUM_PORTS-1:0] tx_er_o,
  output logic [grc_pkg::BUS_W-1:0] txd_o,
  output logic collision_o,
  output logic repeating_o,
  output logic err_sub_o,
  output logic [grc_pkg::PORT_IDX_W-1:0] src_port_o
);

  // Input stage
  logic [NUM_PORTS-1:0] dv_reg;
  logic [NUM_PORTS-1:0] dv_next;
  logic [NUM_PORTS-1:0] er_reg;
  logic [NUM_PORTS-1:0] er_next;
  logic [BUS_W-1:0] rxd_reg;
  logic [BUS_W-1:0] rxd_next;

  // Control stage
  grc_state_t state_reg;
  grc_state_t state_next;
  logic [PORT_IDX_W-1:0] src_reg;
  logic [PORT_IDX_W-1:0] src_next;
  logic err_sub_reg;
  logic err_sub_next;
  logic repeating_reg;
  logic repeating_next;

  // Output stage
  logic [NUM_PORTS-1:0] tx_en_reg;
  logic [NUM_PORTS-1:0] tx_en_next;
  logic [NUM_PORTS-1:0] tx_er_reg;
  logic [NUM_PORTS-1:0] tx_er_next;
  logic [BUS_W-1:0] txd_reg;
  logic [BUS_W-1:0] txd_next;
  logic coll_reg;
  logic coll_next;

  // Detector results on the registered inputs
  logic [NUM_PORTS-1:0] active;
  logic any_active;
  logic collision;
  logic [PORT_IDX_W-1:0] first_port;

  // Source port view
  logic src_dv;
  logic src_er;
  logic src_active;
  logic [OCTET_W-1:0] src_octet;
  logic [OCTET_W-1:0] fwd_octet;
  logic fwd_en;
  logic fwd_er;

  // Inputs are taken as synchronous; one register stage aligns all ports
  // A low clock enable freezes every stage, so the outputs hold
  always_comb
  begin
    dv_next = rx_dv_i;
    er_next = rx_er_i;
    rxd_next = rxd_i;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dv_reg <= '0;
      er_reg <= '0;
      rxd_reg <= '0;
    end
    else if (ce_i)
    begin
      dv_reg <= dv_next;
      er_reg <= er_next;
      rxd_reg <= rxd_next;
    end
  end

  grc_activity u_activity
  (
    .rx_dv_i (dv_reg),
    .rx_er_i (er_reg),
    .active_o (active),
    .any_o (any_active),
    .collision_o (collision),
    .first_o (first_port)
  );

  // Our own transmissions never show up as receive activity, so a port we
  // drive does not count toward collision; this relies on the PHY setting
  always_comb
  begin
    state_next = state_reg;
    src_next = src_reg;
    err_sub_next = err_sub_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        err_sub_next = 1'b0;
        if (collision)
        begin
          state_next = ST_JAM;
        end
        else if (any_active)
        begin
          state_next = ST_REPEAT;
          src_next = first_port;
        end
      end
      ST_REPEAT:
      begin
        if (collision)
        begin
          state_next = ST_JAM;
        end
        else if (!active[src_reg])
        begin
          // A new lone source may start in the same cycle the old one ends
          err_sub_next = 1'b0;
          if (any_active)
          begin
            src_next = first_port;
          end
          else
          begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_JAM:
      begin
        if (!collision)
        begin
          // Jam ends at once; a survivor is repeated, but its packet is
          // already damaged, so the rest goes out as error
          if (any_active)
          begin
            state_next = ST_REPEAT;
            src_next = first_port;
            err_sub_next = 1'b1;
          end
          else
          begin
            state_next = ST_IDLE;
            err_sub_next = 1'b0;
          end
        end
      end
    endcase
    // A violation on the chosen source latches substitution until it ends,
    // the very first octet of a packet included
    if (state_next == ST_REPEAT)
    begin
      if (dv_reg[src_next] && er_reg[src_next])
      begin
        err_sub_next = 1'b1;
      end
    end
    // Registered so the status pin comes straight from a flop
    repeating_next = (state_next == ST_REPEAT);
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= ST_IDLE;
      src_reg <= PORT_ZERO;
      err_sub_reg <= 1'b0;
      repeating_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      src_reg <= src_next;
      err_sub_reg <= err_sub_next;
      repeating_reg <= repeating_next;
    end
  end

  // Forwarded octet from the source chosen for this cycle
  always_comb
  begin
    // Lane index follows the next source so a handover costs no cycle
    src_dv = dv_reg[src_next];
    src_er = er_reg[src_next];
    src_active = active[src_next];
    src_octet = rxd_reg[src_next * OCTET_W +: OCTET_W];
    fwd_en = src_dv;
    fwd_er = src_er;
    fwd_octet = src_octet;
    if (src_dv && (src_er || err_sub_next))
    begin
      // Violation and everything after it go out as error code-groups
      fwd_er = 1'b1;
      fwd_octet = ERR_OCTET;
    end
    if (!src_active)
    begin
      fwd_en = 1'b0;
      fwd_er = 1'b0;
      fwd_octet = IDLE_OCTET;
    end
  end

  // Same two-stage path for every packet keeps start delay fixed
  always_comb
  begin
    tx_en_next = '0;
    tx_er_next = '0;
    txd_next = '0;
    coll_next = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      unique case (state_next)
        ST_JAM:
        begin
          // Jam goes to every port, the colliding ones included
          tx_en_next[p] = 1'b1;
          txd_next[p * OCTET_W +: OCTET_W] = JAM_OCTET;
          coll_next = 1'b1;
        end
        ST_REPEAT:
        begin
          if (PORT_IDX_W'(p) != src_next)
          begin
            tx_en_next[p] = fwd_en;
            tx_er_next[p] = fwd_er;
            txd_next[p * OCTET_W +: OCTET_W] = fwd_octet;
          end
          else
          begin
            // The receiving port stays quiet so its PHY sees no echo
            tx_en_next[p] = 1'b0;
            tx_er_next[p] = 1'b0;
            txd_next[p * OCTET_W +: OCTET_W] = IDLE_OCTET;
          end
        end
        ST_IDLE:
        begin
          tx_en_next[p] = 1'b0;
          tx_er_next[p] = 1'b0;
          txd_next[p * OCTET_W +: OCTET_W] = IDLE_OCTET;
        end
      endcase
    end
  end

  // Fixed two-cycle latency: 8 bit times for packet start, jam start and
  // jam end alike, far inside the 976 bit time budget, with no variation
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_en_reg <= '0;
      tx_er_reg <= '0;
      txd_reg <= '0;
      coll_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      tx_en_reg <= tx_en_next;
      tx_er_reg <= tx_er_next;
      txd_reg <= txd_next;
      coll_reg <= coll_next;
    end
  end

  // Status outputs come straight from registers
  always_comb
  begin
    tx_en_o = tx_en_reg;
    tx_er_o = tx_er_reg;
    txd_o = txd_reg;
    collision_o = coll_reg;
    repeating_o = repeating_reg;
    err_sub_o = err_sub_reg;
    src_port_o = src_reg;
  end

endmodule : grc_core

// *** grc_core_sva.sv ***
// Assertion checker for the repeater core ports
`timescale 1ns/1ps
module grc_core_sva
  import grc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [grc_pkg::NUM_PORTS-1:0] rx_dv_i,
  input wire logic [grc_pkg::NUM_PORTS-1:0] rx_er_i,
  input wire logic [grc_pkg::BUS_W-1:0] rxd_i,
  input wire logic [grc_pkg::NUM_PORTS-1:0] tx_en_o,
  input wire logic [grc_pkg::NUM_PORTS-1:0] tx_er_o,
  input wire logic [grc_pkg::BUS_W-1:0] txd_o,
  input wire logic collision_o,
  input wire logic err_sub_o
);
  default clocking @(posedge mclk_i);
  endclocking
  // Frozen cycles do not count, so a low enable suspends checking
  default disable iff (!rstn_i || !ce_i);
  property p_fwd;
    rx_dv_i == 4'h4 && $past(rx_dv_i) == 4'h4 && $past(rx_dv_i, 2) == 4'h4 && rx_er_i == 4'h0
    && $past(rx_er_i) == 4'h0 && $past(rx_er_i, 2) == 4'h0 && !err_sub_o |-> ##2
    tx_en_o == 4'hb && tx_er_o == 4'h0
    && txd_o == {$past(rxd_i[23:16], 2), IDLE_OCTET, {2{$past(rxd_i[23:16], 2)}}};
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward lanes wrong");
  property p_cv;
    rx_dv_i == 4'h1 && rx_er_i == 4'h1 |-> ##2
    tx_er_o == 4'he && txd_o == {{3{ERR_OCTET}}, IDLE_OCTET};
  endproperty
  a_cv: assert property (p_cv) else $error("code violation not marked");
  property p_sub;
    err_sub_o && rx_dv_i == 4'h1 && rx_er_i[3:1] == 3'h0 && $past(rx_dv_i) == 4'h1
    && $past(rx_er_i[3:1]) == 3'h0 && $past(rx_dv_i, 2) == 4'h1
    |-> ##2 tx_er_o == 4'he && tx_en_o == 4'he;
  endproperty
  a_sub: assert property (p_sub) else $error("substitution stopped early");
  property p_jam;
    $countones(rx_dv_i | rx_er_i) > 1 |-> ##2
    collision_o && tx_en_o == 4'hf && tx_er_o == 4'h0 && txd_o == {4{JAM_OCTET}};
  endproperty
  a_jam: assert property (p_jam) else $error("jam missing");
  property p_jam_end;
    $countones(rx_dv_i | rx_er_i) < 2 |-> ##2 !collision_o;
  endproperty
  a_jam_end: assert property (p_jam_end) else $error("jam too long");
  property p_idle;
    (rx_dv_i | rx_er_i) == 4'h0 |-> ##2 tx_en_o == 4'h0 && tx_er_o == 4'h0 && txd_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_fc;
    rx_er_i == 4'h2 && rx_dv_i == 4'h0 && $past(rx_dv_i | rx_er_i) == 4'h0 |-> ##2
    tx_er_o == 4'hd && tx_en_o == 4'h0 && txd_o[31:16] == {2{$past(rxd_i[15:8], 2)}};
  endproperty
  a_fc: assert property (p_fc) else $error("false carrier dropped");
  property p_start;
    rx_dv_i == 4'h4 && rx_er_i == 4'h0 && $past(rx_dv_i | rx_er_i) == 4'h0 |->
    ##1 tx_en_o == 4'h0 ##1 tx_en_o == 4'hb;
  endproperty
  a_start: assert property (p_start) else $error("start delay wrong");
endmodule : grc_core_sva

bind grc_core grc_core_sva grc_core_sva_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .rx_dv_i(rx_dv_i), .rx_er_i(rx_er_i), .rxd_i(rxd_i), .tx_en_o(tx_en_o), .tx_er_o(tx_er_o),
  .txd_o(txd_o), .collision_o(collision_o), .err_sub_o(err_sub_o));

// *** grc_phy_model.sv ***
// Behavioural model of the PHYs on the repeater ports
`timescale 1ns/1ps
module grc_phy_model
  import grc_pkg::*;
(
  input wire logic mclk_i,
  output logic [grc_pkg::NUM_PORTS-1:0] rx_dv_o,
  output logic [grc_pkg::NUM_PORTS-1:0] rx_er_o,
  output logic [grc_pkg::BUS_W-1:0] rxd_o
);
  initial
  begin
    rx_dv_o = '0;
    rx_er_o = '0;
    rxd_o = '0;
  end
  // Repeater mode: own transmit is never echoed as receive activity
  task automatic beat(input logic [3:0] dv, input logic [3:0] er, input logic [31:0] d);
    logic [BUS_W-1:0] m;
    @(posedge mclk_i);
    #1;
    for (int p = 0; p < NUM_PORTS; p++)
      m[p*8+:8] = {8{dv[p] | er[p]}};
    // Quiet lanes toggle so stale octets never pass for data
    rxd_o = (d & m) | (~rxd_o & ~m);
    rx_dv_o = dv;
    rx_er_o = er;
  endtask : beat
endmodule : grc_phy_model

// *** grc_pkg.sv ***
// Constants and types shared by the gigabit repeater core
package grc_pkg;

  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned PORT_IDX_W = 2;
  localparam int unsigned OCTET_W = 8;
  localparam int unsigned BUS_W = NUM_PORTS * OCTET_W;

  // Timing in picoseconds and bit times
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned BIT_TIME_PS = 1000;
  localparam int unsigned PIPE_DEPTH = 2;
  localparam int unsigned START_PACKET_DELAY_BT = (PIPE_DEPTH * CLK_PERIOD_PS) / BIT_TIME_PS;
  localparam int unsigned START_JAM_DELAY_BT = (PIPE_DEPTH * CLK_PERIOD_PS) / BIT_TIME_PS;
  localparam int unsigned END_JAM_DELAY_BT = (PIPE_DEPTH * CLK_PERIOD_PS) / BIT_TIME_PS;
  localparam int unsigned DELAY_BUDGET_BT = 976;
  localparam int unsigned PACKET_DELAY_VAR_BT = 16;
  localparam int unsigned PREAMBLE_VAR_BT = 8;

  // Octet values driven on the transmit paths
  localparam logic [OCTET_W-1:0] JAM_OCTET = 8'h55;
  localparam logic [OCTET_W-1:0] ERR_OCTET = 8'h0f;
  localparam logic [OCTET_W-1:0] IDLE_OCTET = 8'h00;

  localparam logic [PORT_IDX_W-1:0] PORT_ZERO = 2'h0;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_REPEAT = 3'b010,
    ST_JAM = 3'b100
  } grc_state_t;

  // Number of set bits in a port vector
  function automatic logic [PORT_IDX_W:0] grc_count(input logic [NUM_PORTS-1:0] v);
    logic [PORT_IDX_W:0] n;
    n = '0;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      n = n + {{PORT_IDX_W{1'b0}}, v[i]};
    end
    return n;
  endfunction : grc_count

  // Lowest set bit of a port vector, zero when none
  function automatic logic [PORT_IDX_W-1:0] grc_lowest(input logic [NUM_PORTS-1:0] v);
    logic [PORT_IDX_W-1:0] idx;
    idx = PORT_ZERO;
    for (int i = NUM_PORTS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = PORT_IDX_W'(i);
      end
    end
    return idx;
  endfunction : grc_lowest

endpackage : grc_pkg

// *** tb_top.sv ***
// Self-checking bench for the repeater core
`timescale 1ns/1ps
module tb_top;
  import grc_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic rep, coll, sub;
  logic [PORT_IDX_W-1:0] src;
  logic [NUM_PORTS-1:0] rx_dv, rx_er, tx_en, tx_er;
  logic [BUS_W-1:0] rxd, txd;
  int n_errors = 0;
  int comparisons = 0;
  grc_phy_model grc_phy_model_inst (.mclk_i(mclk_i), .rx_dv_o(rx_dv), .rx_er_o(rx_er), .rxd_o(rxd));
  grc_core grc_core_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .rx_dv_i(rx_dv),
    .rx_er_i(rx_er), .rxd_i(rxd), .tx_en_o(tx_en), .tx_er_o(tx_er), .txd_o(txd),
    .collision_o(coll), .repeating_o(rep), .err_sub_o(sub), .src_port_o(src));
  initial
  begin
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic b(input logic [3:0] dv, input logic [3:0] er, input logic [31:0] d);
    grc_phy_model_inst.beat(dv, er, d);
  endtask : b
  // Outputs seen here answer the input set two beats earlier
  task automatic look(input logic [3:0] en, input logic [3:0] er, input logic [31:0] d);
    chk(32'(tx_en), 32'(en));
    chk(32'(tx_er), 32'(er));
    chk(txd, d);
  endtask : look
  // Status answers the same input as look; the source matters only while repeating
  task automatic look_ctl(input logic r, input logic [1:0] s, input logic e);
    chk(32'(rep), 32'(r));
    if (r)
    begin
      chk(32'(src), 32'(s));
    end
    chk(32'(sub), 32'(e));
  endtask : look_ctl
  task automatic t_forward();
    b(4'h4, 4'h0, 32'h00550000);
    b(4'h4, 4'h0, 32'h00d50000);
    look(4'h0, 4'h0, 32'h0);
    b(4'h4, 4'h0, 32'h00ab0000);
    look(4'hb, 4'h0, 32'h55005555);
    look_ctl(1'b1, 2'h2, 1'b0);
    b(4'h0, 4'h0, 32'h0);
    look(4'hb, 4'h0, 32'hd500d5d5);
    b(4'h0, 4'h0, 32'h0);
    look(4'hb, 4'h0, 32'hab00abab);
    b(4'h0, 4'h0, 32'h0);
    look(4'h0, 4'h0, 32'h0);
  endtask : t_forward
  task automatic t_codeviol();
    b(4'h1, 4'h0, 32'h11);
    b(4'h1, 4'h0, 32'h22);
    b(4'h1, 4'h1, 32'h33);
    look(4'he, 4'h0, 32'h11111100);
    look_ctl(1'b1, 2'h0, 1'b0);
    b(4'h1, 4'h0, 32'h44);
    look(4'he, 4'h0, 32'h22222200);
    b(4'h1, 4'h0, 32'h55);
    look(4'he, 4'he, 32'h0f0f0f00);
    look_ctl(1'b1, 2'h0, 1'b1);
    b(4'h0, 4'h0, 32'h0);
    look(4'he, 4'he, 32'h0f0f0f00);
    b(4'h0, 4'h0, 32'h0);
    look(4'he, 4'he, 32'h0f0f0f00);
    b(4'h0, 4'h0, 32'h0);
    look(4'h0, 4'h0, 32'h0);
    look_ctl(1'b0, 2'h0, 1'b0);
  endtask : t_codeviol
  task automatic t_cv_first();
    b(4'h2, 4'h2, 32'h9900);
    b(4'h2, 4'h0, 32'haa00);
    b(4'h0, 4'h0, 32'h0);
    look(4'hd, 4'hd, 32'h0f0f000f);
    look_ctl(1'b1, 2'h1, 1'b1);
    b(4'h0, 4'h0, 32'h0);
    look(4'hd, 4'hd, 32'h0f0f000f);
    b(4'h0, 4'h0, 32'h0);
    look(4'h0, 4'h0, 32'h0);
  endtask : t_cv_first
  task automatic t_false();
    b(4'h0, 4'h2, 32'h7700);
    b(4'h0, 4'h0, 32'h0);
    b(4'h0, 4'h0, 32'h0);
    look(4'h0, 4'hd, 32'h77770077);
    b(4'h0, 4'h0, 32'h0);
    look(4'h0, 4'h0, 32'h0);
  endtask : t_false
  task automatic t_collide();
    b(4'h1, 4'h0, 32'haa);
    b(4'h9, 4'h0, 32'hbb0000aa);
    b(4'h9, 4'h0, 32'hbb0000aa);
    look(4'he, 4'h0, 32'haaaaaa00);
    b(4'h0, 4'h0, 32'h0);
    look(4'hf, 4'h0, 32'h55555555);
    chk(32'(coll), 32'h1);
    chk(32'(rep), 32'h0);
    b(4'h0, 4'h0, 32'h0);
    look(4'hf, 4'h0, 32'h55555555);
    b(4'h0, 4'h0, 32'h0);
    look(4'h0, 4'h0, 32'h0);
    chk(32'(coll), 32'h0);
  endtask : t_collide
  // Low enable: outputs hold and inputs are not sampled; the octet still offered when it rises is taken
  task automatic t_freeze();
    b(4'h8, 4'h0, 32'h3c000000);
    b(4'h8, 4'h0, 32'h5a000000);
    b(4'h8, 4'h0, 32'h69000000);
    look(4'h7, 4'h0, 32'h003c3c3c);
    ce_i = 1'b0;
    b(4'h8, 4'h0, 32'h77000000);
    look(4'h7, 4'h0, 32'h003c3c3c);
    look_ctl(1'b1, 2'h3, 1'b0);
    b(4'h8, 4'h0, 32'h77000000);
    look(4'h7, 4'h0, 32'h003c3c3c);
    ce_i = 1'b1;
    b(4'h0, 4'h0, 32'h0);
    look(4'h7, 4'h0, 32'h005a5a5a);
    b(4'h0, 4'h0, 32'h0);
    look(4'h7, 4'h0, 32'h00777777);
    b(4'h0, 4'h0, 32'h0);
    look(4'h0, 4'h0, 32'h0);
  endtask : t_freeze
  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (10) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    look(4'h0, 4'h0, 32'h0);
    t_forward();
    t_codeviol();
    t_cv_first();
    t_false();
    t_collide();
    t_freeze();
    complete_run();
  end
  // Whole run needs about 50 cycles; allow ten times that
  initial
  begin
    #2000;
    n_errors++;
    complete_run();
  end
endmodule : tb_top
